// file: verilog/sdosu_server.sv
// sdo server: segmented upload, aborts, abort codes
//
// Functional notes
// [R1] client initiate: command 40, index, subindex
// [R2] initiate answer 41, echoed index/subindex, size bytes 4-7
// [R3] client segment request 60 or 70 by toggle
// [R4] toggle alternates; confirm echoes request toggle
// [R5] toggle starts at zero, also after an abort
// [R6] command bits 3..1 count empty trailing bytes
// [R7] last-segment flag set only in final confirm
// [R8] full middle confirm, toggle set: command 10
// [R9] final 3-byte confirm, toggle clear: command 09
// [R10] abort: command 80, index, subindex, code, own id
// [R11] received abort ends transfer, never confirmed; code drops an abort in ST_OD_WAIT, ST_SEND or with a reply pending
// [R12] client restarts with initiate after an abort
// [R13] abort accepted with or without code; code ignored
// [R14] toggle not alternated aborts with 05030000
// [R15] unknown command aborts with 05040001
// [R16] complete access 06010000; read-only write 06010002
// [R17] no index 06020000; no subindex 06090011
// [R18] unmappable 06040041; mapping over 8 bytes 06040042
// [R19] write too long 06070012; too short 06070013
// [R20] above limit 06090031; below limit 06090032
// [R21] other failures 08000000
// [R22] pdo parameter write while operational 08000022
// [R23] track toggle and count; idle after last or abort
`timescale 1ns/1ps
module sdosu_server #(
  parameter int FIFO_W = sdosu_pkg::FIFO_WIDTH,
  parameter int FIFO_D = sdosu_pkg::FIFO_DEPTH
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic [6:0]  i_node_number,
  input  wire logic        i_nmt_operational,
  input  wire logic        i_rx_valid,
  input  wire logic [10:0] i_rx_cob_id,
  input  wire logic [63:0] i_rx_data,
  output logic             o_tx_valid,
  input  wire logic        i_tx_ready,
  output logic [10:0]      o_tx_cob_id,
  output logic [63:0]      o_tx_data,
  output logic             o_od_req,
  output logic             o_od_write,
  output logic [15:0]      o_od_index,
  output logic [7:0]       o_od_subidx,
  output logic [31:0]      o_od_wdata,
  output logic [2:0]       o_od_wlen,
  input  wire logic        i_od_ack,
  input  wire logic [3:0]  i_od_err,
  input  wire logic [31:0] i_od_size,
  input  wire logic        i_up_valid,
  output logic             o_up_ready,
  input  wire logic [7:0]  i_up_data,
  output logic             o_up_flush,
  output logic             o_busy
);

  typedef struct packed {
    sdosu_pkg::sdosu_state_t state;
    logic                    toggle;
    logic [31:0]             remaining;
    logic [15:0]             index;
    logic [7:0]              subidx;
    logic                    is_write;
    logic [2:0]              take;
    logic [2:0]              seg_cnt;
    logic [55:0]             seg_data;
    logic                    tx_valid;
    logic [10:0]             tx_cob_id;
    logic [63:0]             tx_data;
    logic                    od_req;
    logic [31:0]             od_wdata;
    logic [2:0]              od_wlen;
    logic                    flush;
  } sdosu_st_t;

  sdosu_st_t   st_reg;
  sdosu_st_t   st_next;

  sdosu_fifo_if #(.W(FIFO_W)) up_rd ();

  logic        rx_hit;
  logic [7:0]  rx_cmd;
  logic [15:0] rx_index;
  logic [7:0]  rx_subidx;
  logic [10:0] own_cob_id;
  logic        pdo_locked;
  logic [31:0] od_code;
  logic [2:0]  next_take;
  logic [7:0]  seg_cmd;

  sdosu_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clk_sys  (i_clk_sys),
    .i_rst_n    (i_rst_n),
    .i_flush    (st_reg.flush),
    .i_wr_valid (i_up_valid),
    .o_wr_ready (o_up_ready),
    .i_wr_data  (i_up_data),
    .rd         (up_rd.fifo)
  );

  function automatic logic [63:0] abort_frame(
    input logic [15:0] idx,
    input logic [7:0]  sub,
    input logic [31:0] code
  );
    abort_frame = {code, sub, idx, sdosu_pkg::CMD_ABORT}; // [R10]
  endfunction : abort_frame

  // one frame per cycle at most; a frame is lost while a reply is pending or outside ST_IDLE and ST_UP_RDY, except an abort in ST_COLLECT
  assign rx_hit     = i_rx_valid &&
                      (i_rx_cob_id == sdosu_pkg::RX_COB_BASE +
                                      {4'h0, i_node_number});
  assign rx_cmd     = i_rx_data[7:0];
  assign rx_index   = i_rx_data[23:8];
  assign rx_subidx  = i_rx_data[31:24];
  assign own_cob_id = sdosu_pkg::TX_COB_BASE + {4'h0, i_node_number};

  always_comb
  begin
    pdo_locked = 1'b0;
    if ((rx_index[15:4] == sdosu_pkg::PDO_RX_COMM) ||
        (rx_index[15:4] == sdosu_pkg::PDO_RX_MAP)  ||
        (rx_index[15:4] == sdosu_pkg::PDO_TX_COMM) ||
        (rx_index[15:4] == sdosu_pkg::PDO_TX_MAP))
    begin
      pdo_locked = (rx_index[3:0] <= sdosu_pkg::PDO_LAST_NUM);
    end
  end

  always_comb
  begin
    case (sdosu_pkg::sdosu_od_err_t'(i_od_err))
      sdosu_pkg::OD_NO_OBJECT: od_code = sdosu_pkg::AB_NO_OBJECT; // [R17]
      sdosu_pkg::OD_NO_SUB:    od_code = sdosu_pkg::AB_NO_SUB;    // [R17]
      sdosu_pkg::OD_READ_ONLY: od_code = sdosu_pkg::AB_READ_ONLY; // [R16]
      sdosu_pkg::OD_NOT_MAP:   od_code = sdosu_pkg::AB_NOT_MAP;   // [R18]
      sdosu_pkg::OD_MAP_LONG:  od_code = sdosu_pkg::AB_MAP_LONG;  // [R18]
      sdosu_pkg::OD_TOO_LONG:  od_code = sdosu_pkg::AB_TOO_LONG;  // [R19]
      sdosu_pkg::OD_TOO_SHORT: od_code = sdosu_pkg::AB_TOO_SHORT; // [R19]
      sdosu_pkg::OD_TOO_HIGH:  od_code = sdosu_pkg::AB_TOO_HIGH;  // [R20]
      sdosu_pkg::OD_TOO_LOW:   od_code = sdosu_pkg::AB_TOO_LOW;   // [R20]
      default:                 od_code = sdosu_pkg::AB_GENERAL;   // [R21]
    endcase
  end

  // at most seven bytes per segment
  assign next_take = (st_reg.remaining >= {29'h0, sdosu_pkg::SEG_BYTES}) ?
                     sdosu_pkg::SEG_BYTES : st_reg.remaining[2:0];

  always_comb
  begin
    seg_cmd = 8'h00;
    seg_cmd[sdosu_pkg::CMD_TOGGLE_B] = st_reg.toggle; // [R4] [R8] [R9]
    seg_cmd[3:sdosu_pkg::CMD_EMPTY_LSB] =
      sdosu_pkg::SEG_BYTES - st_reg.take; // [R6]
    seg_cmd[sdosu_pkg::CMD_LAST_B] =
      (st_reg.remaining == {29'h0, st_reg.take}); // [R7]
  end

  always_comb
  begin
    st_next        = st_reg;
    st_next.od_req = 1'b0;
    st_next.flush  = 1'b0;
    up_rd.ready    = 1'b0;
    if (st_reg.tx_valid && i_tx_ready)
    begin
      st_next.tx_valid = 1'b0;
    end
    case (st_reg.state)
      sdosu_pkg::ST_IDLE,
      sdosu_pkg::ST_UP_RDY:
      begin
        if (rx_hit && !st_reg.tx_valid)
        begin
          st_next.index     = rx_index;
          st_next.subidx    = rx_subidx;
          st_next.tx_cob_id = own_cob_id; // [R10]
          if (rx_cmd == sdosu_pkg::CMD_ABORT)
          begin
            // code bytes ignored; no reply
            st_next.state  = sdosu_pkg::ST_IDLE; // [R11] [R13] [R23]
            st_next.toggle = 1'b0;               // [R5]
            st_next.flush  = 1'b1;
          end
          else if (rx_cmd[7:5] == sdosu_pkg::CCS_UPLOAD)
          begin
            st_next.toggle = 1'b0; // [R5] [R12]
            st_next.flush  = 1'b1;
            if (rx_cmd[sdosu_pkg::CMD_ACCESS_B])
            begin
              st_next.state    = sdosu_pkg::ST_IDLE;
              st_next.tx_valid = 1'b1;
              st_next.tx_data  = abort_frame(rx_index, rx_subidx,
                                             sdosu_pkg::AB_ACCESS); // [R16]
            end
            else
            begin
              st_next.is_write = 1'b0; // [R1]
              st_next.od_req   = 1'b1;
              st_next.state    = sdosu_pkg::ST_OD_WAIT;
            end
          end
          else if (rx_cmd[7:5] == sdosu_pkg::CCS_DOWNLOAD)
          begin
            st_next.state = sdosu_pkg::ST_IDLE;
            if (pdo_locked && i_nmt_operational)
            begin
              st_next.tx_valid = 1'b1;
              st_next.tx_data  = abort_frame(rx_index, rx_subidx,
                                             sdosu_pkg::AB_BAD_STATE); // [R22]
            end
            else if (!rx_cmd[1])
            begin
              // only expedited writes are served
              st_next.tx_valid = 1'b1;
              st_next.tx_data  = abort_frame(rx_index, rx_subidx,
                                             sdosu_pkg::AB_GENERAL); // [R21]
            end
            else
            begin
              st_next.is_write = 1'b1;
              st_next.od_wdata = i_rx_data[63:32];
              st_next.od_wlen  = rx_cmd[0] ? 3'h4 - {1'b0, rx_cmd[3:2]} :
                                             3'h4;
              st_next.od_req   = 1'b1;
              st_next.state    = sdosu_pkg::ST_OD_WAIT;
            end
          end
          else if ((rx_cmd[7:5] == sdosu_pkg::CCS_SEGMENT) &&
                   (st_reg.state == sdosu_pkg::ST_UP_RDY))
          begin
            if (rx_cmd[sdosu_pkg::CMD_TOGGLE_B] != st_reg.toggle)
            begin
              st_next.state    = sdosu_pkg::ST_IDLE; // [R23]
              st_next.toggle   = 1'b0;
              st_next.flush    = 1'b1;
              st_next.tx_valid = 1'b1;
              st_next.tx_data  = abort_frame(st_reg.index, st_reg.subidx,
                                             sdosu_pkg::AB_TOGGLE); // [R14]
            end
            else
            begin
              st_next.index    = st_reg.index; // [R3]
              st_next.subidx   = st_reg.subidx;
              st_next.take     = next_take;
              st_next.seg_cnt  = 3'h0;
              st_next.seg_data = 56'h0;
              st_next.state    = sdosu_pkg::ST_COLLECT;
            end
          end
          else
          begin
            // segment request outside an upload counts as unknown
            st_next.state    = sdosu_pkg::ST_IDLE;
            st_next.toggle   = 1'b0;
            st_next.flush    = 1'b1;
            st_next.tx_valid = 1'b1;
            st_next.tx_data  = abort_frame(rx_index, rx_subidx,
                                           sdosu_pkg::AB_BAD_CMD); // [R15]
          end
        end
      end
      sdosu_pkg::ST_OD_WAIT:
      begin
        if (i_od_ack)
        begin
          st_next.tx_valid = 1'b1;
          st_next.state    = sdosu_pkg::ST_IDLE;
          if (sdosu_pkg::sdosu_od_err_t'(i_od_err) != sdosu_pkg::OD_OK)
          begin
            st_next.flush   = 1'b1;
            st_next.tx_data = abort_frame(st_reg.index, st_reg.subidx,
                                          od_code);
          end
          else if (st_reg.is_write)
          begin
            st_next.tx_data = {32'h0, st_reg.subidx, st_reg.index,
                               sdosu_pkg::CMD_DL_ANS};
          end
          else
          begin
            st_next.remaining = i_od_size; // [R23]
            st_next.tx_data   = {i_od_size, st_reg.subidx, st_reg.index,
                                 sdosu_pkg::CMD_INIT_ANS}; // [R2]
            st_next.state     = sdosu_pkg::ST_UP_RDY;
          end
        end
      end
      sdosu_pkg::ST_COLLECT:
      begin
        if (rx_hit && (rx_cmd == sdosu_pkg::CMD_ABORT))
        begin
          st_next.state  = sdosu_pkg::ST_IDLE; // [R11] [R23]
          st_next.toggle = 1'b0;
          st_next.flush  = 1'b1;
        end
        else if (st_reg.seg_cnt != st_reg.take)
        begin
          // source stalls here; the fifo lets it run ahead by its depth
          up_rd.ready = 1'b1;
          if (up_rd.valid)
          begin
            st_next.seg_data[{st_reg.seg_cnt, 3'h0} +: 8] = up_rd.data; // [R6]
            st_next.seg_cnt = st_reg.seg_cnt + 3'h1;
          end
        end
        else if (!st_reg.tx_valid)
        begin
          st_next.tx_valid  = 1'b1;
          st_next.tx_data   = {st_reg.seg_data, seg_cmd}; // [R8] [R9]
          st_next.state     = sdosu_pkg::ST_SEND;
        end
      end
      sdosu_pkg::ST_SEND:
      begin
        if (i_tx_ready)
        begin
          st_next.toggle    = !st_reg.toggle; // [R4]
          st_next.remaining = st_reg.remaining - {29'h0, st_reg.take};
          if (seg_cmd[sdosu_pkg::CMD_LAST_B])
          begin
            st_next.state  = sdosu_pkg::ST_IDLE; // [R23]
            st_next.toggle = 1'b0;               // [R5]
          end
          else
          begin
            st_next.state = sdosu_pkg::ST_UP_RDY;
          end
        end
      end
      default:
      begin
        st_next.state = sdosu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg       <= '0;
      st_reg.state <= sdosu_pkg::ST_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_tx_valid  = st_reg.tx_valid;
  assign o_tx_cob_id = st_reg.tx_cob_id;
  assign o_tx_data   = st_reg.tx_data;
  assign o_od_req    = st_reg.od_req;
  assign o_od_write  = st_reg.is_write;
  assign o_od_index  = st_reg.index;
  assign o_od_subidx = st_reg.subidx;
  assign o_od_wdata  = st_reg.od_wdata;
  assign o_od_wlen   = st_reg.od_wlen;
  assign o_up_flush  = st_reg.flush;
  assign o_busy      = (st_reg.state != sdosu_pkg::ST_IDLE);

endmodule : sdosu_server

// file: verilog/sdosu_pkg.sv
// constants and types of the segmented upload server
package sdosu_pkg;

  localparam logic [10:0] RX_COB_BASE   = 11'h600;
  localparam logic [10:0] TX_COB_BASE   = 11'h580;

  localparam logic [7:0]  CMD_INIT_UP   = 8'h40;
  localparam logic [7:0]  CMD_INIT_ANS  = 8'h41;
  localparam logic [7:0]  CMD_ABORT     = 8'h80;
  localparam logic [7:0]  CMD_DL_ANS    = 8'h60;
  localparam logic [2:0]  CCS_DOWNLOAD  = 3'h1;
  localparam logic [2:0]  CCS_UPLOAD    = 3'h2;
  localparam logic [2:0]  CCS_SEGMENT   = 3'h3;
  localparam int          CMD_TOGGLE_B  = 4;
  localparam int          CMD_ACCESS_B  = 4;
  localparam int          CMD_LAST_B    = 0;
  localparam int          CMD_EMPTY_LSB = 1;
  localparam logic [2:0]  SEG_BYTES     = 3'h7;

  localparam logic [31:0] AB_TOGGLE     = 32'h05030000;
  localparam logic [31:0] AB_BAD_CMD    = 32'h05040001;
  localparam logic [31:0] AB_ACCESS     = 32'h06010000;
  localparam logic [31:0] AB_READ_ONLY  = 32'h06010002;
  localparam logic [31:0] AB_NO_OBJECT  = 32'h06020000;
  localparam logic [31:0] AB_NOT_MAP    = 32'h06040041;
  localparam logic [31:0] AB_MAP_LONG   = 32'h06040042;
  localparam logic [31:0] AB_TOO_LONG   = 32'h06070012;
  localparam logic [31:0] AB_TOO_SHORT  = 32'h06070013;
  localparam logic [31:0] AB_NO_SUB     = 32'h06090011;
  localparam logic [31:0] AB_TOO_HIGH   = 32'h06090031;
  localparam logic [31:0] AB_TOO_LOW    = 32'h06090032;
  localparam logic [31:0] AB_GENERAL    = 32'h08000000;
  localparam logic [31:0] AB_BAD_STATE  = 32'h08000022;

  // pdo groups locked while operational
  localparam logic [11:0] PDO_RX_COMM   = 12'h140;
  localparam logic [11:0] PDO_RX_MAP    = 12'h160;
  localparam logic [11:0] PDO_TX_COMM   = 12'h180;
  localparam logic [11:0] PDO_TX_MAP    = 12'h1a0;
  localparam logic [3:0]  PDO_LAST_NUM  = 4'h7;

  localparam int          FIFO_DEPTH    = 16;
  localparam int          FIFO_WIDTH    = 8;

  typedef enum logic [3:0] {
    OD_OK        = 4'h0,
    OD_NO_OBJECT = 4'h1,
    OD_NO_SUB    = 4'h2,
    OD_READ_ONLY = 4'h3,
    OD_NOT_MAP   = 4'h4,
    OD_MAP_LONG  = 4'h5,
    OD_TOO_LONG  = 4'h6,
    OD_TOO_SHORT = 4'h7,
    OD_TOO_HIGH  = 4'h8,
    OD_TOO_LOW   = 4'h9,
    OD_GENERAL   = 4'ha
  } sdosu_od_err_t;

  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_OD_WAIT = 5'h02,
    ST_UP_RDY  = 5'h04,
    ST_COLLECT = 5'h08,
    ST_SEND    = 5'h10
  } sdosu_state_t;

endpackage : sdosu_pkg

// file: verilog/sdosu_fifo_if.sv
// drain side of the upload byte fifo
`timescale 1ns/1ps
interface sdosu_fifo_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport fifo (output valid, output data, input ready);
  modport user (input valid, input data, output ready);
endinterface : sdosu_fifo_if

// file: verilog/sdosu_fifo.sv
// byte fifo between data source and segment builder
`timescale 1ns/1ps
module sdosu_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst_n,
  input  wire logic         i_flush,
  input  wire logic         i_wr_valid,
  output logic              o_wr_ready,
  input  wire logic [W-1:0] i_wr_data,
  sdosu_fifo_if.fifo        rd
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    full;
  } sdosu_fifo_st_t;

  sdosu_fifo_st_t st_reg;
  sdosu_fifo_st_t st_next;
  logic           push;
  logic           pop;

  always_comb
  begin
    st_next = st_reg;
    push    = i_wr_valid && !st_reg.full;
    pop     = rd.ready && (st_reg.cnt != '0);
    if (push)
    begin
      st_next.mem[st_reg.wp] = i_wr_data;
      st_next.wp             = st_reg.wp + 1'b1;
    end
    if (pop)
    begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (push && !pop)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    // flush wins so stale bytes never leak into the next transfer
    if (i_flush)
    begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0;
    end
    st_next.full = (st_next.cnt == (AW+1)'(DEPTH));
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign o_wr_ready = !st_reg.full;
  assign rd.valid   = (st_reg.cnt != '0);
  assign rd.data    = st_reg.mem[st_reg.rp];

endmodule : sdosu_fifo

// file: dv/sdosu_asserts.sv
// concurrent checks on the upload server ports
`timescale 1ns/1ps
module sdosu_asserts (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire logic [6:0]  i_node_number,
  input wire logic        i_rx_valid,
  input wire logic [10:0] i_rx_cob_id,
  input wire logic [63:0] i_rx_data,
  input wire logic        o_tx_valid,
  input wire logic        i_tx_ready,
  input wire logic [10:0] o_tx_cob_id,
  input wire logic [63:0] o_tx_data,
  input wire logic        o_od_req,
  input wire logic        o_od_write,
  input wire logic [15:0] o_od_index,
  input wire logic [7:0]  o_od_subidx,
  input wire logic        i_od_ack,
  input wire logic [3:0]  i_od_err,
  input wire logic [31:0] i_od_size,
  input wire logic        o_busy
);
  logic        wr_q;
  logic        tog_q;
  logic        wait_q;
  logic [31:0] rem_q;
  logic        rx_me;
  logic        seg_cf;
  assign rx_me = i_rx_valid &&
    i_rx_cob_id == sdosu_pkg::RX_COB_BASE + 11'(i_node_number);
  assign seg_cf = o_tx_valid && o_tx_data[7:5] == 3'h0;
  // wait_q: between confirms, where a client abort is taken
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      wr_q <= 1'b0;
      tog_q <= 1'b0;
      wait_q <= 1'b0;
      rem_q <= 32'h0;
    end
    else
    begin
      if (o_od_req)
        wr_q <= o_od_write;
      if (rx_me && i_rx_data[7:5] == 3'h3 && !o_tx_valid)
        tog_q <= i_rx_data[4];
      if (rx_me && !o_tx_valid)
        wait_q <= 1'b0;
      else if (o_tx_valid && i_tx_ready)
        wait_q <= o_tx_data[7:0] == 8'h41 || (seg_cf && !o_tx_data[0]);
      if (i_od_ack && !wr_q)
        rem_q <= i_od_size;
      else if (seg_cf && i_tx_ready)
        rem_q <= rem_q - 32'(7 - o_tx_data[3:1]);
    end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  sequence s_init_rx;
    rx_me && i_rx_data[7:0] == sdosu_pkg::CMD_INIT_UP && !o_busy &&
      !o_tx_valid;
  endsequence
  sequence s_abort_rx;
    rx_me && i_rx_data[7:0] == sdosu_pkg::CMD_ABORT && !o_tx_valid &&
      (wait_q || !o_busy);
  endsequence
  a_tx_frame_hold: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx_data) && $stable(o_tx_cob_id))
    else $error("tx frame changed");
  a_tx_own_id: assert property (o_tx_valid |->
    o_tx_cob_id == sdosu_pkg::TX_COB_BASE + 11'(i_node_number))
    else $error("tx frame wrong id");
  a_init_lookup: assert property (s_init_rx |=> o_od_req && !o_od_write &&
    o_od_index == $past(i_rx_data[23:8]) &&
    o_od_subidx == $past(i_rx_data[31:24]))
    else $error("no lookup on initiate");
  a_init_answer: assert property (i_od_ack && !wr_q && i_od_err == 4'h0
    |=> o_tx_valid && o_tx_data[7:0] == sdosu_pkg::CMD_INIT_ANS &&
    o_tx_data[63:32] == $past(i_od_size))
    else $error("initiate answer wrong");
  a_err_abort: assert property (i_od_ack && i_od_err != 4'h0 |=>
    o_tx_valid && o_tx_data[7:0] == sdosu_pkg::CMD_ABORT)
    else $error("lookup error not aborted");
  a_abort_silent: assert property (s_abort_rx |=>
    !o_busy && !o_tx_valid)
    else $error("abort not ended quietly");
  a_seg_toggle: assert property (seg_cf |-> o_tx_data[4] == tog_q)
    else $error("confirm toggle wrong");
  a_seg_count: assert property (seg_cf |->
    o_tx_data[0] == (rem_q <= 32'd7) &&
    o_tx_data[3:1] == (rem_q >= 32'd7 ? 3'h0 : 3'(7 - rem_q)))
    else $error("segment count wrong");
endmodule : sdosu_asserts
bind sdosu_server sdosu_asserts i_sdosu_asserts (.*);

// file: dv/sdosu_od_model.sv
// object dictionary and byte source facing the server
`timescale 1ns/1ps
module sdosu_od_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_req,
  input  wire logic [15:0] i_index,
  input  wire logic        i_flush,
  input  wire logic        i_ready,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic [3:0]       o_err,
  output logic [31:0]      o_size,
  output logic             o_valid,
  output logic [7:0]       o_data
);
  logic [2:0]  cnt;
  logic [15:0] idx;
  logic [7:0]  ptr;
  logic [7:0]  len;
  // objects 20xx report the error class in the low nibble
  assign o_err = (idx[15:8] == 8'h20) ? idx[3:0] : 4'h0;
  assign o_size = 32'h00000011;
  assign o_valid = ptr < len;
  // an idle source line flips, not holding its last byte
  assign o_data = (8'h40 + ptr) ^ {8{!o_valid}};
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
    if (!i_rst_n)
    begin
      cnt <= 3'h0;
      idx <= 16'h0000;
      ptr <= 8'h00;
      len <= 8'h00;
      o_ack <= 1'b0;
    end
    else
    begin
      o_ack <= cnt == 3'h1;
      if (i_req)
      begin
        cnt <= i_slow ? 3'h5 : 3'h1;
        idx <= i_index;
      end
      else if (cnt != 3'h0)
        cnt <= cnt - 3'h1;
      if (i_flush)
      begin
        ptr <= 8'h00;
        len <= 8'h00;
      end
      else if (o_ack && o_err == 4'h0)
        len <= 8'h11;
      else if (o_valid && i_ready)
        ptr <= ptr + 8'h01;
    end
endmodule : sdosu_od_model

// file: dv/tb_sdo_segmented_upload_server.sv
// self-checking bench for the upload server
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("[FAIL] %s expected %h seen %h", n, e, g); \
    end \
  end
module tb_sdo_segmented_upload_server;
  localparam logic [10:0] RXID = sdosu_pkg::RX_COB_BASE + 11'h003;
  localparam logic [10:0] TXID = sdosu_pkg::TX_COB_BASE + 11'h003;
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [6:0]  i_node_number = 7'h03;
  logic        i_nmt_operational = 1'b0;
  logic        i_rx_valid = 1'b0;
  logic [10:0] i_rx_cob_id = 11'h000;
  logic [63:0] i_rx_data = 64'h0;
  logic        i_tx_ready = 1'b0;
  logic        o_tx_valid, o_od_req, o_od_write, o_up_ready, o_up_flush;
  logic        o_busy, i_od_ack, i_up_valid;
  logic [10:0] o_tx_cob_id;
  logic [63:0] o_tx_data;
  logic [15:0] o_od_index;
  logic [7:0]  o_od_subidx, i_up_data;
  logic [31:0] o_od_wdata, i_od_size;
  logic [2:0]  o_od_wlen;
  logic [3:0]  i_od_err;
  logic        slow = 1'b0;
  int          errors = 0;
  int          tests_run = 0;
  logic [31:0] codes [1:10];
  always #20 i_clk_sys = ~i_clk_sys;
  sdosu_server i_sdosu_server (.*);
  sdosu_od_model i_sdosu_od_model (.i_clk_sys, .i_rst_n, .i_req(o_od_req),
    .i_index(o_od_index), .i_flush(o_up_flush), .i_ready(o_up_ready),
    .i_slow(slow), .o_ack(i_od_ack), .o_err(i_od_err), .o_size(i_od_size),
    .o_valid(i_up_valid), .o_data(i_up_data));
  function automatic logic [63:0] seg(input logic [7:0] c, input int k);
    seg[7:0] = c;
    for (int i = 1; i < 8; i++)
      seg[8*i+:8] = 8'(8'h40 + k + i - 1);
  endfunction : seg
  function automatic logic [63:0] msk(input int m);
    msk = (64'h1 << (8 * (m + 1))) - 64'h1;
  endfunction : msk
  function automatic logic [63:0] abt(input logic [31:0] code,
    input logic [15:0] ix, input logic [7:0] sb);
    abt = {code, sb, ix, sdosu_pkg::CMD_ABORT};
  endfunction : abt
  task automatic send(input logic [10:0] id, input logic [7:0] c,
    input logic [15:0] ix, input logic [7:0] sb, input logic [31:0] v);
    @(negedge i_clk_sys);
    i_rx_valid = 1'b1;
    i_rx_cob_id = id;
    i_rx_data = {v, sb, ix, c};
    @(negedge i_clk_sys);
    i_rx_valid = 1'b0;
    i_rx_data = ~i_rx_data;
  endtask : send
  // sink stalls two cycles to prove the frame stands
  task automatic recv(input logic [63:0] exp, input logic [63:0] m,
    input string nm);
    int n = 0;
    while (o_tx_valid !== 1'b1 && n < 300) @(negedge i_clk_sys) n++;
    `CHK(nm, TXID, o_tx_cob_id)
    `CHK(nm, exp & m, o_tx_data & m)
    repeat (2) @(negedge i_clk_sys);
    `CHK("frame stands", 1'b1, o_tx_valid)
    i_tx_ready = 1'b1;
    @(negedge i_clk_sys);
    i_tx_ready = 1'b0;
  endtask : recv
  task automatic quiet(input int n);
    logic s = 1'b0;
    repeat (n) @(negedge i_clk_sys) s = s | o_tx_valid;
    `CHK("no frame", 1'b0, s)
  endtask : quiet
  task automatic init(input logic sl);
    slow = sl;
    send(RXID, sdosu_pkg::CMD_INIT_UP, 16'h100a, 8'h00, 32'h0);
    recv({32'h11, 8'h00, 16'h100a, 8'h41}, '1, "init");
  endtask : init
  task automatic up_seg(input logic [7:0] c, input logic [63:0] exp,
    input logic [63:0] m);
    send(RXID, c, 16'h100a, 8'h00, 32'h0);
    recv(exp, m, "segment");
  endtask : up_seg
  task automatic rej(input logic [7:0] c, input logic [15:0] ix,
    input logic [31:0] code);
    send(RXID, c, ix, 8'h00, 32'h0);
    recv(abt(code, ix, 8'h00), '1, "reject");
  endtask : rej
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  initial
  begin
    #2000000;
    errors++;
    give_verdict();
  end
  initial
  begin
    codes = '{sdosu_pkg::AB_NO_OBJECT, sdosu_pkg::AB_NO_SUB,
      sdosu_pkg::AB_READ_ONLY, sdosu_pkg::AB_NOT_MAP, sdosu_pkg::AB_MAP_LONG,
      sdosu_pkg::AB_TOO_LONG, sdosu_pkg::AB_TOO_SHORT,
      sdosu_pkg::AB_TOO_HIGH, sdosu_pkg::AB_TOO_LOW, sdosu_pkg::AB_GENERAL};
    repeat (2) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    `CHK("reset busy", 1'b0, o_busy)
    `CHK("reset ready", 1'b1, o_up_ready)
    init(1'b0);
    repeat (20) @(negedge i_clk_sys);
    `CHK("fifo full", 1'b0, o_up_ready)
    up_seg(8'h60, seg(8'h00, 0), '1);
    up_seg(8'h70, seg(8'h10, 7), '1);
    up_seg(8'h60, seg(8'h09, 14), msk(3));
    `CHK("idle after last", 1'b0, o_busy)
    $display("test upload done");
    init(1'b1);
    up_seg(8'h70, abt(sdosu_pkg::AB_TOGGLE, 16'h100a, 8'h00), '1);
    up_seg(8'h60, abt(sdosu_pkg::AB_BAD_CMD, 16'h100a, 8'h00), '1);
    $display("test toggle done");
    init(1'b0);
    up_seg(8'h60, seg(8'h00, 0), '1);
    send(RXID, 8'h80, 16'h100a, 8'h00, 32'h0);
    quiet(10);
    `CHK("idle after abort", 1'b0, o_busy)
    init(1'b1);
    send(RXID, 8'h80, 16'h100a, 8'h00, 32'h12345678);
    quiet(10);
    init(1'b0);
    up_seg(8'h60, seg(8'h00, 0), '1);
    $display("test abort done");
    for (int e = 1; e <= 10; e++)
      rej(8'h40, 16'h2000 + 16'(e), codes[e]);
    $display("test lookup done");
    rej(8'h50, 16'h100a, sdosu_pkg::AB_ACCESS);
    rej(8'he0, 16'h100a, sdosu_pkg::AB_BAD_CMD);
    rej(8'h21, 16'h2100, sdosu_pkg::AB_GENERAL);
    i_nmt_operational = 1'b1;
    rej(8'h23, 16'h1600, sdosu_pkg::AB_BAD_STATE);
    rej(8'h23, 16'h1a07, sdosu_pkg::AB_BAD_STATE);
    send(RXID, 8'h23, 16'h1408, 8'h00, 32'h5);
    recv({32'h0, 8'h00, 16'h1408, 8'h60}, msk(3), "write");
    `CHK("wdata", {32'h5, 3'h4}, {o_od_wdata, o_od_wlen})
    i_nmt_operational = 1'b0;
    send(RXID, 8'h23, 16'h1600, 8'h00, 32'h5);
    recv({32'h0, 8'h00, 16'h1600, 8'h60}, msk(3), "write");
    send(11'h605, 8'h40, 16'h100a, 8'h00, 32'h0);
    quiet(20);
    $display("test commands done");
    give_verdict();
  end
endmodule : tb_sdo_segmented_upload_server
